// *** common/asc_defs.svh ***
// register offsets, field positions, reset values and timing counts of the serial converter port
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_ADDR_W 8
`define ASC_OFS_CTRL 8'h00
`define ASC_OFS_STATUS 8'h04
`define ASC_OFS_COUNT 8'h08
`define ASC_CTRL_ENABLE_BIT 0
`define ASC_CTRL_RESET 32'h00000001
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2
`define ASC_CLK_PERIOD_NS 40
`define ASC_INTCONV_NS 7500
`define ASC_INTCONV_CYC (`ASC_INTCONV_NS / `ASC_CLK_PERIOD_NS)
`define ASC_TRACK_BIT 4'h5
`define ASC_HOLD_BIT 4'h8
`define ASC_OUT_BITS 4'hc
`define ASC_COM_CHANNEL 4'h8
`endif

// *** common/asc_pkg.sv ***
// types shared by the serial converter port modules
package asc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CTRL = 4'b0010,
        ST_INTCONV = 4'b0100,
        ST_SHIFT = 4'b1000
    } asc_state_type;

    // control byte, most significant bit first
    typedef struct packed {
        logic start;
        logic channel_select_bit2;
        logic channel_select_bit1;
        logic channel_select_bit0;
        logic polarity_select;
        logic input_config_select;
        logic power_clock_mode_hi;
        logic power_clock_mode_lo;
    } asc_ctrl_type;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } asc_pins_type;

    // positive input 0..7, negative input 0..7 or 8 for the common return
    typedef struct packed {
        logic [2:0] pos;
        logic [3:0] neg;
    } asc_mux_type;
endpackage

// *** core/asc_sync.sv ***
// two-flop synchroniser for the serial pins with serial clock edge pulses
module asc_sync
    import asc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire asc_pins_type pins_async,
    output asc_pins_type pins_sync,
    output logic sclk_rise,
    output logic sclk_fall
);
    asc_pins_type meta;
    asc_pins_type next_meta;
    asc_pins_type next_sync;
    logic sclk_prev;
    logic next_sclk_prev;

    // edges are taken from the second stage only, never the metastable first
    always_comb begin
        next_meta = pins_async;
        next_sync = meta;
        next_sclk_prev = pins_sync.sclk;
        sclk_rise = pins_sync.sclk & ~sclk_prev;
        sclk_fall = ~pins_sync.sclk & sclk_prev;
    end

    // select idles high so reset shows a deselected port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            pins_sync <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            sclk_prev <= 1'b0;
        end else begin
            meta <= next_meta;
            pins_sync <= next_sync;
            sclk_prev <= next_sclk_prev;
        end
    end
endmodule

// *** core/asc_chan_decode.sv ***
// maps the channel select field of a control byte onto the input multiplexer
`include "asc_defs.svh"
module asc_chan_decode
    import asc_pkg::*;
(
    input asc_ctrl_type ctrl,
    output asc_mux_type mux
);
    // pairs are (0,1) (2,3) (4,5) (6,7); the top select bit swaps the pair
    always_comb begin
        if (ctrl.input_config_select) begin
            mux.pos = {ctrl.channel_select_bit1, ctrl.channel_select_bit0,
                ctrl.channel_select_bit2}; // R05
            mux.neg = `ASC_COM_CHANNEL; // R06
        end else begin
            mux.pos = {ctrl.channel_select_bit1, ctrl.channel_select_bit0,
                ctrl.channel_select_bit2}; // R09
            mux.neg = {1'b0, ctrl.channel_select_bit1, ctrl.channel_select_bit0,
                ~ctrl.channel_select_bit2}; // R06
        end
    end
endmodule

// *** core/asc_serial_port.sv ***
// serial control-byte port of an 8-channel 10-bit converter with AXI4-Lite status
`include "asc_defs.svh"
// Overview of operation
// [R01] with select low, one input bit is shifted in on each rising serial clock
// [R02] first one after select falls is the start bit, bit 7 of the byte
// [R03] zeros before the start bit are ignored and change nothing
// [R04] byte: start 7, channel 6..4, polarity 3, input config 2, mode 1..0
// [R05] single-ended select codes map to inputs 0..7 against the common return
// [R06] bit 2 one measures against common return, zero measures a channel pair
// [R07] bit 3 picks unipolar or bipolar conversion and the result coding
// [R08] low bits: 00 power-down, 01 fast power-down, 10 internal, 11 external clock
// [R09] differential codes 00, 01, 10 pair inputs 0/1, 2/3, 4/5
// [R10] host runs clock idle low, sampling on the leading edge
// [R11] host uses three full-duplex byte transfers per conversion
// [R12] every conversion is started by shifting in a fresh control byte
// [R13] an all-ones byte converts input 7 single-ended unipolar, external clock
// [R14] external mode: strobe high one serial period right before the result MSB
// [R15] host gives at least 15 serial clocks per external-clock conversion
// [R16] strobe and data output change only on falling serial clock edges
// [R17] data output is high impedance while select is high
// [R18] track after fifth control bit falling edge, hold after the eighth
// [R19] external mode: bit decisions appear on the 12 falling edges after strobe
// [R20] result goes out MSB first, straight binary or twos complement
module asc_serial_port
    import asc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ASC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ASC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic din_pin,
    input wire logic [9:0] analog_code,
    output logic dout_out,
    output logic dout_oe_n,
    output logic conversion_strobe_out,
    output logic strobe_oe_n,
    output asc_mux_type mux_select,
    output logic track_mode,
    output logic powered_down
);
    // result word: ten decisions then two sub-lsb zeros; bipolar flips the offset msb
    function automatic logic [11:0] code_result(input logic [9:0] code, input logic uni);
        code_result = {code[9] ^ ~uni, code[8:0], 2'h0}; // R07 R20
    endfunction
    // byte-lane merge of a register write
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
        input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lane_merge = (old & ~m) | (data & m);
    endfunction
    asc_pins_type pins;
    logic rise, fall;
    asc_mux_type dec_mux;
    asc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins_async('{cs_n: cs_n_pin, sclk: sclk_pin, din: din_pin}),
        .pins_sync(pins),
        .sclk_rise(rise),
        .sclk_fall(fall)
    );
    asc_state_type state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    asc_ctrl_type ctrl, next_ctrl;
    logic [11:0] result, next_result;
    logic [3:0] out_cnt, next_out_cnt;
    logic [7:0] conv_cnt, next_conv_cnt;
    logic [15:0] done_count, next_done_count;
    logic next_dout, next_dout_oe_n, next_strobe, next_strobe_oe_n;
    asc_mux_type next_mux;
    logic next_track, next_powered_down;
    logic [31:0] ctrl_reg, next_ctrl_reg;
    logic active;
    asc_chan_decode u_dec (
        .ctrl(asc_ctrl_type'(shift)),
        .mux(dec_mux)
    );
    // software can park the port; a parked port behaves as deselected
    assign active = ctrl_reg[`ASC_CTRL_ENABLE_BIT] & ~pins.cs_n;
    // serial side: start search, control byte, conversion and result shifting
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ctrl = ctrl;
        next_result = result;
        next_out_cnt = out_cnt;
        next_conv_cnt = conv_cnt;
        next_done_count = done_count;
        next_dout = dout_out;
        next_strobe = conversion_strobe_out;
        next_mux = mux_select;
        next_track = track_mode;
        next_powered_down = powered_down;
        next_dout_oe_n = 1'b0;
        next_strobe_oe_n = 1'b0;
        if (!active) begin
            // deselect aborts any conversion; strobe is cleared and released (high impedance) while deselected
            next_state = ST_IDLE;
            next_bit_cnt = 4'h0;
            next_dout = 1'b0;
            next_strobe = 1'b0;
            next_dout_oe_n = 1'b1; // R17
            next_strobe_oe_n = 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (rise && pins.din) begin // R03
                        next_shift = 8'h01; // R01 R02 R12
                        next_bit_cnt = 4'h1;
                        next_powered_down = 1'b0;
                        next_state = ST_CTRL;
                    end
                end
                ST_CTRL: begin
                    if (rise && bit_cnt != `ASC_HOLD_BIT) begin
                        next_shift = {shift[6:0], pins.din}; // R01
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (fall && bit_cnt == `ASC_TRACK_BIT) begin
                        next_track = 1'b1; // R18
                    end
                    if (fall && bit_cnt == `ASC_HOLD_BIT) begin
                        next_track = 1'b0; // R18
                        next_ctrl = asc_ctrl_type'(shift); // R04 R13
                        next_mux = dec_mux; // R05 R06 R09
                        next_result = code_result(analog_code, shift[3]); // R07
                        next_out_cnt = 4'h0;
                        if (shift[1:0] == 2'h2) begin
                            next_conv_cnt = 8'(`ASC_INTCONV_CYC); // R08
                            next_state = ST_INTCONV;
                        end else begin
                            next_strobe = 1'b1; // R14 R16
                            next_state = ST_SHIFT;
                        end
                    end
                end
                ST_INTCONV: begin
                    // strobe keeps its value while the internal clock converts: low unless an earlier internal conversion left it high
                    if (conv_cnt != 8'h00) begin
                        next_conv_cnt = conv_cnt - 8'h01;
                    end else if (fall) begin
                        next_strobe = 1'b1; // R08 R16
                        next_state = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (fall) begin
                        if (!(ctrl.power_clock_mode_hi && !ctrl.power_clock_mode_lo)) begin
                            next_strobe = 1'b0; // R14
                        end
                        if (out_cnt == `ASC_OUT_BITS) begin
                            next_dout = 1'b0;
                            next_done_count = done_count + 16'h0001;
                            next_powered_down = ~ctrl.power_clock_mode_hi; // R08
                            next_state = ST_IDLE;
                        end else begin
                            next_dout = result[4'hb - out_cnt]; // R16 R19 R20
                            next_out_cnt = out_cnt + 4'h1;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ctrl <= '0;
            result <= 12'h000;
            out_cnt <= 4'h0;
            conv_cnt <= 8'h00;
            done_count <= 16'h0000;
            dout_out <= 1'b0;
            dout_oe_n <= 1'b1;
            conversion_strobe_out <= 1'b0;
            strobe_oe_n <= 1'b1;
            mux_select <= '0;
            track_mode <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ctrl <= next_ctrl;
            result <= next_result;
            out_cnt <= next_out_cnt;
            conv_cnt <= next_conv_cnt;
            done_count <= next_done_count;
            dout_out <= next_dout;
            dout_oe_n <= next_dout_oe_n;
            conversion_strobe_out <= next_strobe;
            strobe_oe_n <= next_strobe_oe_n;
            mux_select <= next_mux;
            track_mode <= next_track;
            powered_down <= next_powered_down;
        end
    end
    // register slave: address and data are taken separately, the answer follows both
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [`ASC_ADDR_W-1:0] waddr, next_waddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_ctrl_reg = ctrl_reg;
        next_awready = s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid;
        next_wready = s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `ASC_RESP_OKAY;
            if (waddr == `ASC_OFS_CTRL) begin
                next_ctrl_reg = lane_merge(ctrl_reg, wdata, wstrb) & 32'h00000001;
            end else if (waddr != `ASC_OFS_STATUS && waddr != `ASC_OFS_COUNT) begin
                next_bresp = `ASC_RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `ASC_RESP_OKAY;
            case (s_axi_araddr)
                `ASC_OFS_CTRL: next_rdata = ctrl_reg;
                `ASC_OFS_STATUS: next_rdata = {21'h0, powered_down, track_mode,
                    state != ST_IDLE, ctrl};
                `ASC_OFS_COUNT: next_rdata = {16'h0000, done_count};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `ASC_RESP_SLVERR;
                end
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= '0;
            wdata <= 32'h00000000;
            wstrb <= 4'h0;
            ctrl_reg <= `ASC_CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            ctrl_reg <= next_ctrl_reg;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
    // checks on the serial side
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_zero_ignored: assert property ((active && state == ST_IDLE && rise && !pins.din)
        |=> state == ST_IDLE) else $error("zero before start changed state"); // R03
    a_start_begins: assert property ((active && state == ST_IDLE && rise && pins.din)
        |=> state == ST_CTRL && bit_cnt == 4'h1) else $error("start bit missed"); // R02
    a_track_at_five: assert property ((active && state == ST_CTRL && fall && bit_cnt == 4'h5)
        |=> track_mode) else $error("tracking not entered"); // R18
    a_hold_fields: assert property ((active && state == ST_CTRL && fall && bit_cnt == 4'h8)
        |=> !track_mode && ctrl == $past(shift)) else $error("hold or byte latch wrong"); // R04
    a_msb_after_strobe: assert property ((active && state == ST_SHIFT && fall && out_cnt == 4'h0
        && ctrl.power_clock_mode_hi && ctrl.power_clock_mode_lo)
        |=> !conversion_strobe_out && dout_out == result[11]) else $error("msb slot wrong"); // R14
    a_out_fall_only: assert property (($changed(dout_out) || $changed(conversion_strobe_out))
        |-> $past(fall) || $past(!active)) else $error("output moved off a falling edge"); // R16
    a_deselect_hiz: assert property ($rose(pins.cs_n) |=> ##1 dout_oe_n && strobe_oe_n)
        else $error("data output not released"); // R17
    a_single_mux: assert property ((state == ST_SHIFT && ctrl.input_config_select)
        |-> mux_select.neg == 4'h8) else $error("single-ended not on common"); // R05
    a_bit_count: assert property (state == ST_SHIFT |-> out_cnt <= 4'hc)
        else $error("more than twelve decisions"); // R19
    c_external: cover property (state == ST_SHIFT && out_cnt == 4'hc && fall && ctrl == 8'hff);
    c_internal: cover property (state == ST_INTCONV ##[1:250] state == ST_SHIFT);
    c_differential: cover property (state == ST_SHIFT && !ctrl.input_config_select);
endmodule

// *** tb/asc_host_model.sv ***
// serial master model: mode-0 host that selects the port, clocks bytes and reads back
module asc_host_model (
    input wire logic aclk,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic din_pin,
    input wire logic dout_out,
    input wire logic dout_oe_n,
    input wire logic conversion_strobe_out,
    input wire logic track_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_dout;
    logic dout_line;

    // idle low serial clock, select high until a frame starts
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        din_pin = 1'b0;
        last_dout = 1'b0;
    end

    // a released line shows the inverse of its last value, never a kind constant
    always @(posedge aclk) begin
        if (!dout_oe_n) last_dout <= dout_out;
    end
    assign dout_line = dout_oe_n ? ~last_dout : dout_out;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic select(input logic lvl);
        cs_n_pin <= lvl;
        wait_clk(8);
    endtask

    // one bit per 320 ns: data set while low, read back at the end of the high phase
    task automatic shift(input int n, input logic [23:0] tx, output logic [23:0] rx,
                         output logic [23:0] sb, output logic [23:0] tk);
        rx = '0;
        sb = '0;
        tk = '0;
        for (int i = n - 1; i >= 0; i--) begin
            din_pin <= tx[i];
            wait_clk(4);
            sclk_pin <= 1'b1;
            wait_clk(4);
            rx[i] = dout_line;
            sb[i] = conversion_strobe_out;
            tk[i] = track_mode;
            sclk_pin <= 1'b0;
        end
    endtask
endmodule

// *** tb/tb_adc_serial_control_byte_port.sv ***
// self-checking bench: AXI4-Lite status access and serial control-byte conversions
module tb_adc_serial_control_byte_port
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, cs_n_pin, sclk_pin, din_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] analog_code;
    logic dout_out, dout_oe_n, conversion_strobe_out, strobe_oe_n, track_mode, powered_down;
    asc_mux_type mux_select;
    int failures = 0;
    int checked = 0;
    int conv = 0;

    asc_serial_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin), .din_pin(din_pin), .analog_code(analog_code),
        .dout_out(dout_out), .dout_oe_n(dout_oe_n),
        .conversion_strobe_out(conversion_strobe_out), .strobe_oe_n(strobe_oe_n),
        .mux_select(mux_select), .track_mode(track_mode), .powered_down(powered_down));

    asc_host_model host_u (.aclk(aclk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .din_pin(din_pin), .dout_out(dout_out), .dout_oe_n(dout_oe_n),
        .conversion_strobe_out(conversion_strobe_out), .track_mode(track_mode));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        failures++;
        finish_test();
    endtask

    // address and data offered together, bready held up until the response
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             output logic [1:0] resp);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) timeout();
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        int n;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) timeout();
    endtask

    function automatic asc_mux_type exp_mux(input logic [7:0] c);
        asc_mux_type m;
        m.pos = {c[5], c[4], c[6]};
        m.neg = c[2] ? 4'h8 : {1'b0, m.pos ^ 3'h1};
        return m;
    endfunction

    // unipolar is straight binary, bipolar flips the top bit of the offset code
    function automatic logic [9:0] exp_result(input logic [9:0] code, input logic uni);
        return uni ? code : {~code[9], code[8:0]};
    endfunction

    // one serial-clocked conversion with leading zero padding
    task automatic run_ext(input logic [7:0] ctrl, input int pad);
        logic [23:0] rx, sb, tk;
        logic [31:0] rd;
        logic [1:0] rs;
        analog_code <= 10'($urandom);
        host_u.select(1'b0);
        host_u.shift(pad, 24'h0, rx, sb, tk);
        host_u.shift(24, {ctrl, 16'h0}, rx, sb, tk);
        check_word(rx[14:5], exp_result(analog_code, ctrl[3]));
        check_word(sb, 24'h008000);
        check_word(tk, 24'h070000);
        check_word(mux_select, exp_mux(ctrl));
        host_u.select(1'b1);
        check_word(dout_oe_n & strobe_oe_n, 32'h1);
        check_word(powered_down, {31'h0, ~ctrl[1]});
        axi_read(8'h04, rd, rs);
        check_word(rd[7:0], ctrl);
        conv++;
    endtask

    initial begin
        logic [23:0] rx, sb, tk;
        logic [31:0] rd;
        logic [1:0] rs;
        logic [7:0] ctrl, addr;
        logic [31:0] data;
        logic [1:0] ers;
        logic en;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        analog_code = '0;
        void'($urandom(61228));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        check_word(dout_oe_n & strobe_oe_n, 32'h1);
        axi_read(8'h00, rd, rs);
        check_word(rd, 32'h1);
        axi_read(8'h0c, rd, rs);
        check_resp(rs, 2'h2);
        axi_write(8'h0c, 32'hffffffff, rs);
        check_resp(rs, 2'h2);
        // random register traffic, lanes and read-back
        en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            addr = {3'h0, 3'($urandom), 2'h0};
            ers = addr < 8'h0c ? 2'h0 : 2'h2;
            data = $urandom;
            s_axi_wstrb <= 4'($urandom);
            axi_write(addr, data, rs);
            check_resp(rs, ers);
            if (addr == 8'h00 && s_axi_wstrb[0]) en = data[0];
            axi_read(addr, rd, rs);
            check_resp(rs, ers);
            check_word(rd, addr == 8'h00 ? {31'h0, en} : 32'h0);
        end
        s_axi_wstrb <= 4'hf;
        axi_write(8'h00, 32'h1, rs);
        $display("test registers done");
        // twelve zeros with no start bit, then an all-ones byte and random bytes in serial-clock modes
        host_u.select(1'b0);
        host_u.shift(12, 24'hff0000, rx, sb, tk);
        host_u.select(1'b1);
        check_word(dout_oe_n, 32'h1);
        run_ext(8'hff, 0);
        for (int i = 0; i < 10; i++) begin
            ctrl = {1'b1, 7'($urandom)};
            if (ctrl[1:0] == 2'b10) ctrl[0] = 1'b1;
            run_ext(ctrl, i % 6);
        end
        $display("test serial clock modes done");
        // internal clock: strobe low during conversion, then high until deselect
        ctrl = {1'b1, 5'($urandom), 2'b10};
        analog_code <= 10'($urandom);
        host_u.select(1'b0);
        host_u.shift(8, {16'h0, ctrl}, rx, sb, tk);
        check_word(sb[7:0], 32'h0);
        host_u.wait_clk(200);
        host_u.shift(16, 24'h0, rx, sb, tk);
        check_word(sb[15:0], 32'h7fff);
        check_word(rx[13:4], exp_result(analog_code, ctrl[3]));
        host_u.select(1'b1);
        conv++;
        $display("test internal clock done");
        // disabled port neither drives nor converts
        axi_write(8'h00, 32'h0, rs);
        host_u.select(1'b0);
        host_u.shift(24, 24'hff0000, rx, sb, tk);
        check_word(dout_oe_n, 32'h1);
        host_u.select(1'b1);
        axi_write(8'h00, 32'h1, rs);
        axi_read(8'h08, rd, rs);
        check_word(rd[15:0], 32'(conv));
        $display("test disable done");
        finish_test();
    end
endmodule
